// ==== include/uhtf_regs.vh ====
// register map, field positions and timing counts for the token/frame block
`ifndef UHTF_REGS_VH
`define UHTF_REGS_VH

`define UHTF_OFF_ADDR      8'h00
`define UHTF_OFF_FRAME_LOW_BITS      8'h04
`define UHTF_OFF_FRAME_HIGH_BITS      8'h08
`define UHTF_OFF_TOK       8'h0C
`define UHTF_OFF_SOF       8'h10
`define UHTF_OFF_CTRL      8'h14
`define UHTF_OFF_STAT      8'h18

`define UHTF_ADDR_LS_BIT   7
`define UHTF_CTRL_SOF_GENERATION_ENABLE    0
`define UHTF_CTRL_HOSTEN   1
`define UHTF_STAT_BUSY     0

`define UHTF_PID_SETUP     4'hD
`define UHTF_PID_IN        4'h9
`define UHTF_PID_OUT       4'h1
`define UHTF_PID_SOF       4'h5

`define UHTF_CLK_HZ        40000000
`define UHTF_SOF_PERIOD_US 1000
`define UHTF_SOF_CYCLES    ((`UHTF_CLK_HZ / 1000000) * `UHTF_SOF_PERIOD_US)
`define UHTF_TOK_CYCLES    5'h10
`define UHTF_RESET_VAL     32'h0000_0000

`endif

// ==== rtl/uhtf_sof_timer.v ====
// one millisecond start-of-frame tick generator with frame counter
`include "uhtf_regs.vh"
`default_nettype none
module uhtf_sof_timer #(
    parameter SOF_CYCLES = `UHTF_SOF_CYCLES
) (
    input  wire        pclk,       // module clock
    input  wire        presetn,    // async reset, active low
    input  wire        enable,     // sof generation on
    output reg         tick,       // one-cycle pulse each frame
    output reg  [10:0] frame       // frame number to send
);
    reg [15:0] cnt_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
            frame <= 11'h000;
        end else if (!enable) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else if (cnt_r == SOF_CYCLES[15:0] - 16'h0001) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b1;
            frame <= frame + 11'h001;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/uhtf_top.v ====
// token, frame-number and sof-threshold registers behind an apb slave
//
// Summary of operation
// - address bit 7 set means next token goes out at low speed
// - address bits 6-0 hold the readable, writable device address
// - each received sof loads frame number bits 7-0 into frame-low
// - each received sof loads frame number bits 10-8 into frame-high
// - token type 1101 setup, 1001 in, 0001 out
// - address, frame-low, token, threshold bits 31-8 read zero
// - frame-high bits 31-3 read zero
// - threshold count is 8-bit read/write, reset to zero
// - host mode with sof enabled sends a sof every millisecond
//
// The register offsets and register access over APB were decided locally.
`include "uhtf_regs.vh"
`default_nettype none
module uhtf_top (
    input  wire        pclk,          // 40 MHz module clock
    input  wire        presetn,       // async reset, active low
    input  wire        psel,          // apb select
    input  wire        penable,       // apb access phase
    input  wire        pwrite,        // apb write
    input  wire [7:0]  paddr,         // apb byte address
    input  wire [31:0] pwdata,        // apb write data
    output reg  [31:0] prdata,        // apb read data
    output reg         pready,        // apb ready
    output reg         pslverr,       // apb error on unmapped address
    input  wire        sof_rx,        // sof token received pulse
    input  wire [10:0] sof_rx_frame,  // frame number of received sof
    input  wire        tok_done,      // link finished current token
    output reg         tok_start,     // one-cycle token launch
    output reg  [3:0]  tok_pid,       // token type to send
    output reg  [6:0]  tok_addr,      // target device address
    output reg  [3:0]  tok_ep,        // target endpoint
    output reg         tok_low_speed, // launch at low speed
    output reg         token_in_progress, // token busy
    output reg         sof_tx,        // host sof launch pulse
    output reg  [10:0] sof_tx_frame,  // frame number of sent sof
    output reg  [7:0]  sof_threshold_count // threshold to link logic
);
    localparam ST_IDLE = 2'd0;
    localparam ST_BUSY = 2'd1;

    reg        low_speed_select_r;
    reg [6:0]  target_device_address_r;
    reg [7:0]  frame_low_bits_r;
    reg [2:0]  frame_high_bits_r;
    reg [7:0]  token_command_r;
    reg [7:0]  sof_threshold_r;
    reg        sof_generation_enable_r;
    reg        host_enable_r;
    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [4:0]  tok_cnt_r;
    reg [31:0] rdata_nxt;
    reg        err_nxt;
    wire       tick;
    wire [10:0] gen_frame;

    wire setup_ph = psel && !penable;
    wire wr_en    = setup_ph && pwrite;
    wire rd_en    = setup_ph && !pwrite;

    // decode used only by the error path; write and read paths decode paddr in their own case
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `UHTF_OFF_ADDR) || (a == `UHTF_OFF_FRAME_LOW_BITS) ||
                     (a == `UHTF_OFF_FRAME_HIGH_BITS) || (a == `UHTF_OFF_TOK)  ||
                     (a == `UHTF_OFF_SOF)  || (a == `UHTF_OFF_CTRL) ||
                     (a == `UHTF_OFF_STAT);
        end
    endfunction

    function pid_valid;
        input [3:0] p;
        begin
            pid_valid = (p == `UHTF_PID_SETUP) || (p == `UHTF_PID_IN) ||
                        (p == `UHTF_PID_OUT);
        end
    endfunction

    wire tok_wr = wr_en && (paddr == `UHTF_OFF_TOK);

    uhtf_sof_timer u_sof (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (sof_generation_enable_r && host_enable_r),
        .tick    (tick),
        .frame   (gen_frame)
    );

    // register writes, taken in the setup cycle so access ends at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_speed_select_r      <= 1'b0;
            target_device_address_r <= 7'h00;
            token_command_r         <= 8'h00;
            sof_threshold_r         <= 8'h00;
            sof_generation_enable_r <= 1'b0;
            host_enable_r           <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `UHTF_OFF_ADDR: begin
                    low_speed_select_r      <= pwdata[`UHTF_ADDR_LS_BIT];
                    target_device_address_r <= pwdata[6:0];
                end
                `UHTF_OFF_TOK: begin
                    // busy writes are dropped so a running token holds
                    if (state_r == ST_IDLE)
                        token_command_r <= pwdata[7:0];
                end
                `UHTF_OFF_SOF:  sof_threshold_r <= pwdata[7:0];
                `UHTF_OFF_CTRL: begin
                    sof_generation_enable_r <= pwdata[`UHTF_CTRL_SOF_GENERATION_ENABLE];
                    host_enable_r           <= pwdata[`UHTF_CTRL_HOSTEN];
                end
                default: ;
            endcase
        end
    end

    // frame capture
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_low_bits_r  <= 8'h00;
            frame_high_bits_r <= 3'h0;
        end else if (sof_rx) begin
            frame_low_bits_r  <= sof_rx_frame[7:0];
            frame_high_bits_r <= sof_rx_frame[10:8];
        end
    end

    // token sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (tok_wr && pid_valid(pwdata[7:4]))
                    state_nxt = ST_BUSY;
            end
            ST_BUSY: begin
                // busy ends on the link's answer or after a fixed timeout
                if (tok_done || tok_cnt_r == `UHTF_TOK_CYCLES - 5'h01)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r           <= ST_IDLE;
            tok_cnt_r         <= 5'd0;
            tok_start         <= 1'b0;
            tok_pid           <= 4'h0;
            tok_addr          <= 7'h00;
            tok_ep            <= 4'h0;
            tok_low_speed     <= 1'b0;
            token_in_progress <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            tok_start <= 1'b0;
            // launch with current address, endpoint, speed
            if (state_r == ST_IDLE && state_nxt == ST_BUSY) begin
                tok_start     <= 1'b1;
                tok_pid       <= pwdata[7:4];
                tok_ep        <= pwdata[3:0];
                tok_addr      <= target_device_address_r;
                tok_low_speed <= low_speed_select_r;
            end
            if (state_r == ST_BUSY)
                tok_cnt_r <= tok_cnt_r + 5'd1;
            else
                tok_cnt_r <= 5'd0;
            token_in_progress <= (state_nxt == ST_BUSY);
        end
    end

    // sof transmit and threshold outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sof_tx              <= 1'b0;
            sof_tx_frame        <= 11'h000;
            sof_threshold_count <= 8'h00;
        end else begin
            sof_tx              <= tick;
            if (tick)
                sof_tx_frame    <= gen_frame;
            sof_threshold_count <= sof_threshold_r;
        end
    end

    // read mux; upper bits stay zero
    always @* begin
        rdata_nxt = 32'h0000_0000;
        err_nxt   = !mapped(paddr);
        case (paddr)
            `UHTF_OFF_ADDR:
                rdata_nxt[7:0] = {low_speed_select_r,
                                  target_device_address_r};
            `UHTF_OFF_FRAME_LOW_BITS: rdata_nxt[7:0] = frame_low_bits_r;
            `UHTF_OFF_FRAME_HIGH_BITS: rdata_nxt[2:0] = frame_high_bits_r;
            `UHTF_OFF_TOK:  rdata_nxt[7:0] = token_command_r;
            `UHTF_OFF_SOF:  rdata_nxt[7:0] = sof_threshold_r;
            `UHTF_OFF_CTRL: begin
                rdata_nxt[`UHTF_CTRL_SOF_GENERATION_ENABLE]  = sof_generation_enable_r;
                rdata_nxt[`UHTF_CTRL_HOSTEN] = host_enable_r;
            end
            `UHTF_OFF_STAT:
                rdata_nxt[`UHTF_STAT_BUSY] = token_in_progress;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // apb answer: ready in the access cycle, zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph && err_nxt;
            if (rd_en)
                prdata <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== tb/uhtf_top_sva.sv ====
// assertions on the apb, token and sof ports of the token/frame block
`default_nettype none
module uhtf_top_sva (
    input wire logic        pclk,         // clock
    input wire logic        presetn,      // reset, low
    input wire logic        psel,         // select
    input wire logic        penable,      // access
    input wire logic        pwrite,       // write
    input wire logic [7:0]  paddr,        // address
    input wire logic [31:0] pwdata,       // write data
    input wire logic [31:0] prdata,       // read data
    input wire logic        pready,       // ready
    input wire logic        pslverr,      // error
    input wire logic        tok_start,    // launch
    input wire logic [3:0]  tok_pid,      // type
    input wire logic [3:0]  tok_ep,       // endpoint
    input wire logic        token_in_progress, // busy
    input wire logic        sof_tx,       // sof out
    input wire logic [7:0]  sof_threshold_count // threshold
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire setup = psel && !penable;
    wire rd_ok = pready && !pwrite;
    wire tok_wr = setup && pwrite && paddr == 8'h0C;
    wire pid_ok = pwdata[7:4] == 4'hD || pwdata[7:4] == 4'h9
        || pwdata[7:4] == 4'h1;
    chk_ready_access: assert property (setup |=> pready)
        else $error("no ready in access phase");
    chk_ready_cause: assert property (!setup |=> !pready)
        else $error("ready without setup");
    chk_err_mapped: assert property (pready && paddr <= 8'h18 &&
        paddr[1:0] == 2'b00 |-> !pslverr) else $error("error on mapped");
    chk_tok_launch: assert property (tok_wr && !token_in_progress
        && pid_ok |=> tok_start && token_in_progress
        && tok_pid == $past(pwdata[7:4])
        && tok_ep == $past(pwdata[3:0])) else $error("token not launched");
    chk_tok_reserved: assert property (tok_wr && !pid_ok |=> !tok_start)
        else $error("reserved type launched");
    chk_busy_bound: assert property ($rose(token_in_progress) |->
        ##[1:18] !token_in_progress) else $error("busy never clears");
    chk_read_upper: assert property (rd_ok && paddr != 8'h08
        && paddr <= 8'h10 |-> prdata[31:8] == 24'h00_0000)
        else $error("upper bits not zero");
    chk_read_frame_high_bits: assert property (rd_ok && paddr == 8'h08
        |-> prdata[31:3] == 29'h0) else $error("frame high upper not zero");
    chk_thr_copy: assert property (setup && pwrite && paddr == 8'h10
        |=> ##1 sof_threshold_count == $past(pwdata[7:0], 2))
        else $error("threshold copy wrong");
    chk_sof_pulse: assert property (sof_tx |=> !sof_tx)
        else $error("sof pulse too long");
    cover property (tok_start);
    cover property (sof_tx);
    cover property (pslverr);
endmodule
bind uhtf_top uhtf_top_sva chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tok_start, .tok_pid,
    .tok_ep, .token_in_progress, .sof_tx, .sof_threshold_count);
`default_nettype wire

// ==== tb/uhtf_cable_model.sv ====
// cable partner: answers tokens after a delay and delivers received sofs
`default_nettype none
module uhtf_cable_model (
    input  wire logic        pclk,         // clock
    input  wire logic        presetn,      // reset, low
    input  wire logic        tok_start,    // token launch
    input  wire logic        sof_req,      // send a sof
    input  wire logic [10:0] sof_num,      // its frame number
    input  wire logic [4:0]  done_dly,     // answer delay, 0 never
    output var  logic        sof_rx,       // sof received
    output var  logic [10:0] sof_rx_frame, // frame number
    output var  logic        tok_done      // token finished
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 5'h00;
            tok_done <= 1'b0;
            sof_rx <= 1'b0;
            sof_rx_frame <= 11'h7FF;
        end else begin
            sof_rx <= sof_req;
            // frame valid only with the pulse
            sof_rx_frame <= sof_req ? sof_num : ~sof_rx_frame;
            tok_done <= (cnt_r == 5'h01);
            if (tok_start)
                cnt_r <= done_dly;
            else if (cnt_r != 5'h00)
                cnt_r <= cnt_r - 5'h01;
        end
    end
endmodule
`default_nettype wire

// ==== tb/uhtf_top_tb.sv ====
// self-checking bench for the token/frame register block
`include "uhtf_regs.vh"
`default_nettype none
module uhtf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, sof_req, perr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    logic [10:0] sof_num;
    logic [4:0]  done_dly;
    logic [15:0] seen_tok;
    wire  [31:0] prdata;
    wire  pready, pslverr, sof_rx, tok_done, tok_start, tok_low_speed;
    wire  token_in_progress, sof_tx;
    wire  [10:0] sof_rx_frame, sof_tx_frame;
    wire  [3:0]  tok_pid, tok_ep;
    wire  [6:0]  tok_addr;
    wire  [7:0]  sof_threshold_count;
    int err_total = 0, tests_run = 0, launches = 0, n, k;
    logic [3:0] pids [3] = '{4'hD, 4'h9, 4'h1};
    logic [4:0] dlys [3] = '{5'h01, 5'h04, 5'h00};
    uhtf_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sof_rx, .sof_rx_frame,
        .tok_done, .tok_start, .tok_pid, .tok_addr, .tok_ep, .tok_low_speed,
        .token_in_progress, .sof_tx, .sof_tx_frame, .sof_threshold_count);
    uhtf_cable_model far (.pclk, .presetn, .tok_start, .sof_req, .sof_num,
        .done_dly, .sof_rx, .sof_rx_frame, .tok_done);
    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (tok_start === 1'b1) begin
        launches <= launches + 1;
        seen_tok <= {tok_low_speed, tok_addr, tok_pid, tok_ep};
    end
    task chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count is assumed; the watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd   = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask
    task close_out;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge pclk);
        err_total++;
        close_out;
    end
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
        pwdata = 0; sof_req = 0; sof_num = 0; done_dly = 5'h01;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (n = 0; n < 5; n++) rdc(8'(n * 4), 0, "reset");
        xfer(`UHTF_OFF_ADDR, 1, 32'hFFFF_FFFF);
        rdc(`UHTF_OFF_ADDR, 32'h0000_00FF, "addr");
        xfer(`UHTF_OFF_SOF, 1, 32'hFFFF_FF4A);
        rdc(`UHTF_OFF_SOF, 32'h0000_004A, "thr");
        chk("thr out", {24'h0, sof_threshold_count}, 32'h0000_004A);
        xfer(`UHTF_OFF_FRAME_LOW_BITS, 1, 32'hFFFF_FFFF);
        xfer(`UHTF_OFF_FRAME_HIGH_BITS, 1, 32'hFFFF_FFFF);
        rdc(`UHTF_OFF_FRAME_LOW_BITS, 0, "frame_low_bits wr");
        rdc(`UHTF_OFF_FRAME_HIGH_BITS, 0, "frame_high_bits wr");
        for (n = 0; n < 2; n++) begin
            sof_num <= n ? 11'h7FF : 11'h5A5;
            sof_req <= 1;
            @(posedge pclk) sof_req <= 0;
            @(posedge pclk);
            rdc(`UHTF_OFF_FRAME_LOW_BITS, n ? 32'hFF : 32'hA5, "frame_low_bits");
            rdc(`UHTF_OFF_FRAME_HIGH_BITS, n ? 32'h7 : 32'h5, "frame_high_bits");
        end
        for (n = 0; n < 3; n++) begin
            xfer(`UHTF_OFF_ADDR, 1, {24'h0, n[0], 7'h2A});
            rdc(`UHTF_OFF_STAT, 0, "idle");
            done_dly <= dlys[n];
            xfer(`UHTF_OFF_TOK, 1, {24'h0, pids[n], 4'(n + 3)});
            while (token_in_progress !== 1'b0) begin
                @(posedge pclk);
            end
            chk("launch", 32'(launches), 32'(n + 1));
            chk("token", {16'h0, seen_tok},
                {16'h0, n[0], 7'h2A, pids[n], 4'(n + 3)});
        end
        xfer(`UHTF_OFF_TOK, 1, 32'h0000_0023);
        repeat (3) @(posedge pclk);
        chk("reserved", 32'(launches), 32'h0000_0003);
        rdc(`UHTF_OFF_TOK, 32'h0000_0023, "tok rd");
        xfer(8'h1C, 0, 32'h0000_0000);
        chk("slverr", {31'h0, perr}, 32'h0000_0001);
        xfer(`UHTF_OFF_CTRL, 1, 32'h0000_0003);
        for (n = 0; n < 2; n++) begin
            k = 0;
            do begin @(posedge pclk); k++; end
            while (sof_tx !== 1'b1 && k < 41000);
        end
        chk("sof period", 32'(k), 32'd40000);
        chk("sof frame", {21'h0, sof_tx_frame}, 32'h0000_0002);
        close_out;
    end
endmodule
`default_nettype wire
